// ==== design/ism_master.sv ====
// Operation
// - Enable plus master mode starts master operation.
// - Disable or reset clears start/stop flags.
// - Firmware mode: only start/stop detection active.
// - Irq flag on detects, bytes, acks, restart.
// - Master mode irq on request self-clear or ninth clock only.
// - Busy buffer write discarded, sets write collision.
// - Request bit writes ignored during start.
// - Restart begins next transfer, keeps bus.
// - Address byte then direction, then acked bytes.
// - Released clock: counter waits for high clock.
// - Start: timed high, data low, timed hold.
// - Start collision: lines low or early clock low.
// - Restart: clock low, data up, clock up, data low.
// - Restart ends with request cleared, data low.
// - Restart request ignored unless idle.
// - Restart collision on data low or clock fall.
// - Buffer write sets full flag, starts bits.
// - Eighth clock fall clears full, releases data.
// - Ninth clock ack sampled into result bit.
// - After ninth clock irq, clock held low.
// - Stop: data low, clock up, data up, irq.
//
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ism_master
   import ism_pkg::*;
(
   // Clock and reset.
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Two-wire bus pins, open drain.
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe
);
   import ism_pkg::*;

   typedef struct packed {
      ism_state_t st;
      logic [7:0] cnt;
      logic [3:0] bitn;
      logic [7:0] shreg;
      logic [7:0] shbuf;
      logic [7:0] reload;
      logic [3:0] mode;
      logic       en, fw_scl, fw_sda;
      logic       start_request_bit, restart_request_bit, stop_request_bit, ackres;
      logic       sdet, pdet, bf, irq, write_collision_flag, bcol;
      ism_drive_t drv;
      logic       scl1, scl2, scl3, sda1, sda2, sda3;
      ism_wr_t    wr;
      logic [31:0] rdata;
   } ism_regs_t;

   ism_regs_t q, next_q;
   logic      scl, sda, tick, master, fwmode, wr_buf, wr_c2, wr_st;
   logic [7:0] wd;

   function automatic logic is_timed(input ism_state_t s);
      is_timed = !(s inside {ISM_IDLE, ISM_RS_LOW, ISM_RS_RISE, ISM_TX_RISE,
                             ISM_SP_SDA, ISM_SP_RISE, ISM_SP_DET});
   endfunction

   assign scl    = q.scl2;
   assign sda    = q.sda2;
   assign tick   = (q.cnt == 8'h00);
   assign master = q.en && (q.mode == ISM_MODE_MASTER);
   assign fwmode = q.en && (q.mode == ISM_MODE_FW);
   assign wd     = hwdata[7:0];
   assign wr_buf = q.wr.sel && (q.wr.addr == ISM_A_BUF);
   assign wr_c2  = q.wr.sel && (q.wr.addr == ISM_A_CTRL2);
   assign wr_st  = q.wr.sel && (q.wr.addr == ISM_A_STATUS);

   always_comb
   begin
      next_q = q;
      next_q.scl1 = scl_i;
      next_q.scl2 = q.scl1;
      next_q.scl3 = q.scl2;
      next_q.sda1 = sda_i;
      next_q.sda2 = q.sda1;
      next_q.sda3 = q.sda2;
      if (is_timed(q.st) && !tick)
      begin
         next_q.cnt = q.cnt - 8'h01;
      end
      // Register writes take effect in the data phase; clears come first so sets win.
      next_q.wr.sel  = hsel && htrans[1] && hready && hwrite;
      next_q.wr.addr = haddr[4:0];
      if (q.wr.sel && q.wr.addr == ISM_A_CTRL1)
      begin
         next_q.mode   = wd[ISM_C1_MODE +: 4];
         next_q.en     = wd[ISM_C1_EN];
         next_q.fw_scl = wd[ISM_C1_FW_SCL];
         next_q.fw_sda = wd[ISM_C1_FW_SDA];
      end
      if (q.wr.sel && q.wr.addr == ISM_A_RELOAD)
      begin
         next_q.reload = wd;
      end
      if (wr_st)
      begin
         next_q.sdet = q.sdet && !wd[ISM_S_SDET];
         next_q.pdet = q.pdet && !wd[ISM_S_PDET];
         next_q.irq  = q.irq && !wd[ISM_S_IRQ];
         next_q.write_collision_flag = q.write_collision_flag && !wd[ISM_S_WRITE_COLLISION_FLAG];
         next_q.bcol = q.bcol && !wd[ISM_S_BCOL];
      end
      // Requests are only accepted once any start in flight has finished.
      if (wr_c2 && master && !q.start_request_bit && q.st == ISM_IDLE)
      begin
         next_q.start_request_bit  = wd[ISM_C2_SEN];
         next_q.restart_request_bit = wd[ISM_C2_RESTART_REQUEST_BIT];
         next_q.stop_request_bit  = wd[ISM_C2_PEN];
      end
      // Detection sees the sampled lines, so the bus state is always real.
      if (q.en && scl && q.sda3 && !sda)
      begin
         next_q.sdet = 1'b1;
         next_q.pdet = 1'b0;
         if (fwmode)
         begin
            next_q.irq = 1'b1;
         end
      end
      if (q.en && scl && !q.sda3 && sda)
      begin
         next_q.pdet = 1'b1;
         next_q.sdet = 1'b0;
         if (fwmode)
         begin
            next_q.irq = 1'b1;
         end
      end
      if (wr_buf)
      begin
         if (master && q.st == ISM_IDLE && !q.start_request_bit && !q.restart_request_bit && !q.stop_request_bit)
         begin
            next_q.shbuf = wd;
            next_q.shreg = wd;
            next_q.bf    = 1'b1;
            next_q.bitn  = 4'h0;
            next_q.drv.scl_oe = 1'b1;
            next_q.drv.sda_oe = !wd[ISM_LAST_BIT[2:0]];
            next_q.cnt   = q.reload;
            next_q.st    = ISM_TX_LOW;
         end
         else
         begin
            next_q.write_collision_flag = 1'b1;
         end
      end
      case (q.st)
         ISM_IDLE:
         begin
            if (master && q.start_request_bit)
            begin
               if (scl && sda)
               begin
                  next_q.cnt = q.reload;
                  next_q.st  = ISM_ST_WAIT;
               end
               else if (!scl && !sda)
               begin
                  next_q.bcol = 1'b1;
                  next_q.start_request_bit  = 1'b0;
               end
            end
            else if (master && q.restart_request_bit)
            begin
               next_q.drv.scl_oe = 1'b1;
               next_q.st = ISM_RS_LOW;
            end
            else if (master && q.stop_request_bit)
            begin
               next_q.drv.sda_oe = 1'b1;
               next_q.drv.scl_oe = 1'b1;
               next_q.st = ISM_SP_SDA;
            end
         end
         ISM_ST_WAIT:
         begin
            if (!scl)
            begin
               next_q.bcol = 1'b1;
               next_q.start_request_bit  = 1'b0;
               next_q.st   = ISM_IDLE;
            end
            else if (tick && sda)
            begin
               next_q.drv.sda_oe = 1'b1;
               next_q.sdet = 1'b1;
               next_q.pdet = 1'b0;
               next_q.cnt  = q.reload;
               next_q.st   = ISM_ST_HOLD;
            end
         end
         ISM_ST_HOLD:
         begin
            if (tick)
            begin
               next_q.start_request_bit = 1'b0;
               next_q.irq = 1'b1;
               next_q.st  = ISM_IDLE;
            end
         end
         ISM_RS_LOW:
         begin
            if (!scl)
            begin
               next_q.drv.sda_oe = 1'b0;
               next_q.cnt = q.reload;
               next_q.st  = ISM_RS_SDA;
            end
         end
         ISM_RS_SDA:
         begin
            if (tick && sda)
            begin
               next_q.drv.scl_oe = 1'b0;
               next_q.st = ISM_RS_RISE;
            end
         end
         ISM_RS_RISE:
         begin
            if (scl && !sda)
            begin
               next_q.bcol = 1'b1;
               next_q.restart_request_bit = 1'b0;
               next_q.st   = ISM_IDLE;
            end
            else if (scl)
            begin
               next_q.cnt = q.reload;
               next_q.st  = ISM_RS_HIGH;
            end
         end
         ISM_RS_HIGH:
         begin
            if (!scl)
            begin
               next_q.bcol = 1'b1;
               next_q.restart_request_bit = 1'b0;
               next_q.st   = ISM_IDLE;
            end
            else if (tick)
            begin
               next_q.drv.sda_oe = 1'b1;
               next_q.sdet = 1'b1;
               next_q.pdet = 1'b0;
               next_q.cnt  = q.reload;
               next_q.st   = ISM_RS_DLOW;
            end
         end
         ISM_RS_DLOW:
         begin
            if (tick)
            begin
               next_q.drv.scl_oe = 1'b1;
               next_q.restart_request_bit = 1'b0;
               next_q.irq  = 1'b1;
               next_q.st   = ISM_IDLE;
            end
         end
         ISM_TX_LOW:
         begin
            if (tick)
            begin
               next_q.drv.scl_oe = 1'b0;
               next_q.st = ISM_TX_RISE;
            end
         end
         ISM_TX_RISE:
         begin
            // A slave stretching the clock stalls the counter here.
            if (scl)
            begin
               next_q.cnt = q.reload;
               next_q.st  = ISM_TX_HIGH;
            end
         end
         ISM_TX_HIGH:
         begin
            if (tick)
            begin
               next_q.drv.scl_oe = 1'b1;
               next_q.cnt  = q.reload;
               next_q.bitn = q.bitn + 4'h1;
               next_q.shreg = {q.shreg[6:0], 1'b0};
               next_q.drv.sda_oe = !q.shreg[6];
               next_q.st = ISM_TX_LOW;
               if (q.bitn == ISM_LAST_BIT)
               begin
                  next_q.bf = 1'b0;
                  next_q.drv.sda_oe = 1'b0;
               end
               if (q.bitn == ISM_ACK_BIT)
               begin
                  next_q.ackres = sda;
                  next_q.irq = 1'b1;
                  next_q.drv.sda_oe = q.drv.sda_oe;
                  next_q.st = ISM_IDLE;
               end
            end
         end
         ISM_SP_SDA:
         begin
            if (!sda)
            begin
               next_q.cnt = q.reload;
               next_q.st  = ISM_SP_LOW;
            end
         end
         ISM_SP_LOW:
         begin
            if (tick)
            begin
               next_q.drv.scl_oe = 1'b0;
               next_q.st = ISM_SP_RISE;
            end
         end
         ISM_SP_RISE:
         begin
            if (scl)
            begin
               next_q.cnt = q.reload;
               next_q.st  = ISM_SP_HIGH;
            end
         end
         ISM_SP_HIGH:
         begin
            if (tick)
            begin
               next_q.drv.sda_oe = 1'b0;
               next_q.st = ISM_SP_DET;
            end
         end
         ISM_SP_DET:
         begin
            if (scl && sda)
            begin
               next_q.pdet = 1'b1;
               next_q.sdet = 1'b0;
               next_q.cnt  = q.reload;
               next_q.st   = ISM_SP_END;
            end
         end
         ISM_SP_END:
         begin
            if (tick)
            begin
               next_q.stop_request_bit = 1'b0;
               next_q.irq = 1'b1;
               next_q.st  = ISM_IDLE;
            end
         end
         default:
         begin
            next_q.st = ISM_IDLE;
         end
      endcase
      if (fwmode)
      begin
         next_q.drv.scl_oe = !q.fw_scl;
         next_q.drv.sda_oe = !q.fw_sda;
      end
      if (!q.en)
      begin
         next_q.st   = ISM_IDLE;
         next_q.drv  = '0;
         next_q.start_request_bit  = 1'b0;
         next_q.restart_request_bit = 1'b0;
         next_q.stop_request_bit  = 1'b0;
         next_q.sdet = 1'b0;
         next_q.pdet = 1'b0;
      end
      // Read data is prepared in the address phase so the slave never waits.
      case (haddr[4:0])
         ISM_A_CTRL1:  next_q.rdata = {24'h0, q.fw_sda, q.fw_scl, q.en, 1'b0, q.mode};
         ISM_A_CTRL2:  next_q.rdata = {25'h0, q.ackres, 3'h0, q.stop_request_bit, q.restart_request_bit, q.start_request_bit};
         ISM_A_STATUS: next_q.rdata = {26'h0, q.bcol, q.write_collision_flag, q.irq, q.bf, q.pdet, q.sdet};
         ISM_A_BUF:    next_q.rdata = {24'h0, q.shbuf};
         ISM_A_RELOAD: next_q.rdata = {24'h0, q.reload};
         default:      next_q.rdata = 32'h0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q <= '0;
         q.scl1 <= 1'b1;
         q.scl2 <= 1'b1;
         q.scl3 <= 1'b1;
         q.sda1 <= 1'b1;
         q.sda2 <= 1'b1;
         q.sda3 <= 1'b1;
      end
      else
      begin
         q <= next_q;
      end
   end

   // Zero-wait slave: ready is low only in reset, response never changes; both stay registered.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
         scl_o     <= 1'b0;
         sda_o     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         scl_o     <= 1'b0;
         sda_o     <= 1'b0;
      end
   end

   assign hrdata = q.rdata;
   assign scl_oe = q.drv.scl_oe;
   assign sda_oe = q.drv.sda_oe;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_disable_clears_flags: assert property (!q.en |=> !q.sdet && !q.pdet)
      else $error("Start/stop flags survive a disable.");
   a_write_collision_flag_keeps_buffer: assert property ((wr_buf && q.st != ISM_IDLE)
      |=> q.write_collision_flag && q.shbuf == $past(q.shbuf))
      else $error("Busy buffer write not discarded.");
   a_start_early_clock: assert property ((q.st == ISM_ST_WAIT && !scl && q.en)
      |=> q.bcol && q.st == ISM_IDLE)
      else $error("Start collision missed.");
   a_start_data_held: assert property ((q.st == ISM_ST_HOLD && q.en) |-> q.drv.sda_oe)
      else $error("Data released during start hold.");
   a_rise_counter_stall: assert property ((q.st == ISM_TX_RISE && !scl && q.en)
      |=> q.cnt == $past(q.cnt))
      else $error("Counter ran while clock held low.");
   a_ack_sampled: assert property ((q.st == ISM_TX_HIGH && q.bitn == ISM_ACK_BIT
      && tick && q.en)
      |=> q.ackres == $past(sda) && q.irq && q.drv.scl_oe && q.st == ISM_IDLE)
      else $error("Acknowledge not captured at ninth clock.");
   a_eighth_fall: assert property ((q.st == ISM_TX_HIGH && q.bitn == ISM_LAST_BIT
      && tick && q.en && !wr_buf) |=> !q.bf && !q.drv.sda_oe)
      else $error("Eighth clock fall left data driven.");
   a_stop_done: assert property ((q.st == ISM_SP_END && tick && q.en)
      |=> !q.stop_request_bit && q.irq && q.st == ISM_IDLE)
      else $error("Stop did not complete cleanly.");
   a_restart_ignored: assert property ((wr_c2 && q.st != ISM_IDLE && !q.restart_request_bit)
      |=> !q.restart_request_bit)
      else $error("Restart request taken while busy.");

   c_start_done: cover property (q.st == ISM_ST_HOLD && tick);
   c_byte_done: cover property (q.st == ISM_TX_HIGH && q.bitn == ISM_ACK_BIT && tick);
   c_stop_done: cover property (q.st == ISM_SP_END && tick);
   c_collision: cover property (!q.bcol ##1 q.bcol);
endmodule
`default_nettype wire

// ==== design/ism_pkg.sv ====
package ism_pkg;
   localparam logic [4:0] ISM_A_CTRL1  = 5'h00;
   localparam logic [4:0] ISM_A_CTRL2  = 5'h04;
   localparam logic [4:0] ISM_A_STATUS = 5'h08;
   localparam logic [4:0] ISM_A_BUF    = 5'h0c;
   localparam logic [4:0] ISM_A_RELOAD = 5'h10;
   // First control register fields.
   localparam int ISM_C1_MODE   = 0;
   localparam int ISM_C1_EN     = 5;
   localparam int ISM_C1_FW_SCL = 6;
   localparam int ISM_C1_FW_SDA = 7;
   localparam logic [3:0] ISM_MODE_MASTER = 4'h8;
   localparam logic [3:0] ISM_MODE_FW     = 4'hb;
   // Second control register fields.
   localparam int ISM_C2_SEN  = 0;
   localparam int ISM_C2_RESTART_REQUEST_BIT = 1;
   localparam int ISM_C2_PEN  = 2;
   localparam int ISM_C2_ACK  = 6;
   // Status register fields, flags other than BF clear by writing one.
   localparam int ISM_S_SDET = 0;
   localparam int ISM_S_PDET = 1;
   localparam int ISM_S_BF   = 2;
   localparam int ISM_S_IRQ  = 3;
   localparam int ISM_S_WRITE_COLLISION_FLAG = 4;
   localparam int ISM_S_BCOL = 5;
   localparam logic [3:0] ISM_LAST_BIT = 4'h7;
   localparam logic [3:0] ISM_ACK_BIT  = 4'h8;

   typedef enum logic [4:0] {
      ISM_IDLE, ISM_ST_WAIT, ISM_ST_HOLD,
      ISM_RS_LOW, ISM_RS_SDA, ISM_RS_RISE, ISM_RS_HIGH, ISM_RS_DLOW,
      ISM_TX_LOW, ISM_TX_RISE, ISM_TX_HIGH,
      ISM_SP_SDA, ISM_SP_LOW, ISM_SP_RISE, ISM_SP_HIGH, ISM_SP_DET, ISM_SP_END
   } ism_state_t;

   typedef struct packed {
      logic       scl_oe;
      logic       sda_oe;
   } ism_drive_t;

   typedef struct packed {
      logic       sel;
      logic [4:0] addr;
   } ism_wr_t;
endpackage

// ==== testbench/ism_slave_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ism_slave_model #(
   parameter logic [6:0] ADDR = 7'h2a
) (
   // Clock and bus lines.
   input  wire logic       hclk,
   input  wire logic       scl,
   input  wire logic       sda,
   // Control and observation.
   input  wire logic [3:0] stretch,
   output logic            scl_oe,
   output logic            sda_oe,
   output logic [7:0]      last_byte,
   output logic [3:0]      starts
);
   logic       pscl;
   logic       psda;
   logic       act;
   logic       first;
   logic       sel;
   logic       ok;
   logic [3:0] bits;
   logic [7:0] sr;
   logic [5:0] hold;

   initial
   begin
      {pscl, psda, act, first, sel, ok} = 6'h30;
      {scl_oe, sda_oe, bits, sr, hold} = 20'h0;
      last_byte = 8'h00;
      starts = 4'h0;
   end

   // Edges are seen on the raw lines, so the model reacts sooner than the master.
   always @(posedge hclk)
   begin
      pscl <= scl;
      psda <= sda;
      if (hold != 6'h00)
         hold <= hold - 6'h01;
      else
         scl_oe <= 1'b0;
      if (scl && pscl && psda && !sda)
      begin
         act <= 1'b1;
         first <= 1'b1;
         bits <= 4'h0;
         starts <= starts + 4'h1;
      end
      else if (scl && pscl && !psda && sda)
      begin
         act <= 1'b0;
         sda_oe <= 1'b0;
      end
      else if (act && scl && !pscl)
      begin
         if (bits < 4'h8)
            sr <= {sr[6:0], sda};
         bits <= bits + 4'h1;
      end
      else if (act && !scl && pscl)
      begin
         if (stretch != 4'h0)
         begin
            scl_oe <= 1'b1;
            hold <= {stretch, 2'b00};
         end
         if (bits == 4'h8)
         begin
            ok = first ? (sr[7:1] == ADDR) : sel;
            sda_oe <= ok;
            sel <= ok;
            first <= 1'b0;
            last_byte <= sr;
         end
         else if (bits == 4'h9)
         begin
            sda_oe <= 1'b0;
            bits <= 4'h0;
         end
      end
   end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ism_pkg::*;
   localparam logic [31:0] MST  = (32'h1 << ISM_C1_EN) | {28'h0, ISM_MODE_MASTER};
   localparam logic [31:0] FW   = (32'h1 << ISM_C1_EN) | {28'h0, ISM_MODE_FW};
   localparam logic [31:0] SDET = 32'h1 << ISM_S_SDET;
   localparam logic [31:0] PDET = 32'h1 << ISM_S_PDET;
   localparam logic [31:0] BF   = 32'h1 << ISM_S_BF;
   localparam logic [31:0] IRQ  = 32'h1 << ISM_S_IRQ;
   localparam logic [31:0] WRITE_COLLISION_FLAG = 32'h1 << ISM_S_WRITE_COLLISION_FLAG;
   localparam logic [31:0] BCOL = 32'h1 << ISM_S_BCOL;
   localparam logic [31:0] ACKR = 32'h1 << ISM_C2_ACK;
   localparam int          RLD  = 4;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, scl_o, sda_o;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans;
   logic        m_scl_oe, m_sda_oe, s_scl_oe, s_sda_oe, pull_scl, pull_sda, pl;
   logic [3:0]  stretch, starts;
   logic [7:0]  last_byte;
   int          err_total, compares, cyc, run, min_hi, min_lo;
   wire         scl_l = !(m_scl_oe | s_scl_oe | pull_scl);
   wire         sda_l = !(m_sda_oe | s_sda_oe | pull_sda);

   ism_master i_ism_master (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_i(scl_l), .scl_o(scl_o),
      .scl_oe(m_scl_oe), .sda_i(sda_l), .sda_o(sda_o), .sda_oe(m_sda_oe));
   ism_slave_model i_ism_slave_model (.hclk(hclk), .scl(scl_l), .sda(sda_l),
      .stretch(stretch), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .last_byte(last_byte),
      .starts(starts));

   initial
   begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   task automatic close_out();
      if (err_total == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {27'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   task automatic rchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r & m, e);
   endtask

   task automatic wait_irq();
      logic [31:0] r = 32'h0;
      while (r[ISM_S_IRQ] !== 1'b1)
      begin
         bus(1'b0, ISM_A_STATUS, 32'h0, r);
      end
   endtask

   task automatic send(input logic [7:0] b, input logic ak);
      logic [31:0] r;
      bus(1'b1, ISM_A_BUF, {24'h0, b}, r);
      bus(1'b1, ISM_A_BUF, {24'h0, ~b}, r);
      rchk(ISM_A_STATUS, BF | WRITE_COLLISION_FLAG, BF | WRITE_COLLISION_FLAG);
      rchk(ISM_A_BUF, 32'hff, {24'h0, b});
      wait_irq();
      rchk(ISM_A_STATUS, BF | IRQ, IRQ);
      rchk(ISM_A_CTRL2, ACKR, ak ? ACKR : 32'h0);
      chk({24'h0, last_byte}, {24'h0, b});
      chk({31'h0, scl_l}, 32'h0);
      bus(1'b1, ISM_A_STATUS, 32'h3f, r);
   endtask

   // Shortest high and low phase of the clock line while the master runs.
   always @(posedge hclk)
   begin
      cyc++;
      run <= (scl_l == pl) ? run + 1 : 1;
      pl <= scl_l;
      if (scl_l != pl && pl && run < min_hi)
         min_hi <= run;
      if (scl_l != pl && !pl && run < min_lo)
         min_lo <= run;
      if (cyc == 40000)
      begin
         err_total++;
         close_out();
      end
   end

   initial
   begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = 69'h0;
      {pull_scl, pull_sda, pl, stretch} = 7'h10;
      {err_total, compares, cyc, run, min_hi, min_lo} = {128'h0, 32'd999, 32'd999};
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      chk({30'h0, m_scl_oe, m_sda_oe}, 32'h0);
      chk({29'h0, hresp, scl_o, sda_o}, 32'h0);
      rchk(ISM_A_STATUS, 32'h3f, 32'h0);
      rchk(5'h14, 32'hffffffff, 32'h0);
      bus(1'b1, ISM_A_RELOAD, RLD, q);
      bus(1'b1, ISM_A_CTRL1, MST, q);
      stretch <= 4'h3;
      bus(1'b1, ISM_A_CTRL2, 32'h1, q);
      bus(1'b1, ISM_A_BUF, 32'h99, q);
      bus(1'b1, ISM_A_CTRL2, 32'h2, q);
      wait_irq();
      rchk(ISM_A_STATUS, SDET | WRITE_COLLISION_FLAG | IRQ | BF, SDET | WRITE_COLLISION_FLAG | IRQ);
      rchk(ISM_A_CTRL2, 32'h7, 32'h0);
      chk({30'h0, scl_l, sda_l}, 32'h2);
      chk({28'h0, starts}, 32'h1);
      bus(1'b1, ISM_A_STATUS, 32'h3f, q);
      send(8'h54, 1'b0);
      stretch <= 4'h0;
      send(8'hc3, 1'b0);
      bus(1'b1, ISM_A_CTRL2, 32'h2, q);
      wait_irq();
      rchk(ISM_A_CTRL2, 32'h7, 32'h0);
      rchk(ISM_A_STATUS, SDET | IRQ | BCOL, SDET | IRQ);
      chk({28'h0, starts}, 32'h2);
      chk({30'h0, scl_l, sda_l}, 32'h0);
      bus(1'b1, ISM_A_STATUS, 32'h3f, q);
      send(8'h33, 1'b1);
      bus(1'b1, ISM_A_CTRL2, 32'h4, q);
      wait_irq();
      rchk(ISM_A_STATUS, PDET | IRQ, PDET | IRQ);
      rchk(ISM_A_CTRL2, 32'h7, 32'h0);
      chk({30'h0, scl_l, sda_l}, 32'h3);
      chk({31'h0, min_hi > RLD && min_lo > RLD}, 32'h1);
      bus(1'b1, ISM_A_CTRL1, 32'h08, q);
      rchk(ISM_A_STATUS, SDET | PDET, 32'h0);
      bus(1'b1, ISM_A_CTRL1, MST, q);
      bus(1'b1, ISM_A_STATUS, 32'h3f, q);
      pull_sda <= 1'b1;
      repeat (20) @(posedge hclk);
      rchk(ISM_A_STATUS, SDET | PDET | IRQ, SDET);
      pull_sda <= 1'b0;
      repeat (20) @(posedge hclk);
      rchk(ISM_A_STATUS, SDET | PDET | IRQ, PDET);
      pull_scl <= 1'b1;
      pull_sda <= 1'b1;
      bus(1'b1, ISM_A_CTRL2, 32'h1, q);
      repeat (40) @(posedge hclk);
      rchk(ISM_A_STATUS, BCOL, BCOL);
      rchk(ISM_A_CTRL2, 32'h7, 32'h0);
      chk({30'h0, m_scl_oe, m_sda_oe}, 32'h0);
      pull_scl <= 1'b0;
      pull_sda <= 1'b0;
      bus(1'b1, ISM_A_STATUS, 32'h3f, q);
      bus(1'b1, ISM_A_CTRL2, 32'h1, q);
      pull_scl <= 1'b1;
      repeat (20) @(posedge hclk);
      rchk(ISM_A_STATUS, BCOL, BCOL);
      rchk(ISM_A_CTRL2, 32'h7, 32'h0);
      chk({30'h0, m_scl_oe, m_sda_oe}, 32'h0);
      pull_scl <= 1'b0;
      bus(1'b1, ISM_A_CTRL1, FW | 32'hc0, q);
      bus(1'b1, ISM_A_STATUS, 32'h3f, q);
      bus(1'b1, ISM_A_CTRL1, FW | 32'h40, q);
      repeat (10) @(posedge hclk);
      chk({31'h0, sda_l}, 32'h0);
      rchk(ISM_A_STATUS, SDET | PDET | IRQ, SDET | IRQ);
      bus(1'b1, ISM_A_STATUS, 32'h3f, q);
      bus(1'b1, ISM_A_CTRL1, FW | 32'hc0, q);
      repeat (10) @(posedge hclk);
      rchk(ISM_A_STATUS, SDET | PDET | IRQ, PDET | IRQ);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      rchk(ISM_A_STATUS, SDET | PDET, 32'h0);
      close_out();
   end
endmodule
`default_nettype wire
